// ===== hw/fam_pkg.sv
// Shared constants, opcodes and types of the flash address-mode interpreter
package fam_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] REG_SEG  = 8'h00;
  localparam logic [7:0] REG_CFG  = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  // Field positions
  localparam int CFG_QPE   = 0;
  localparam int CFG_WIDE  = 5;
  localparam int CFG_DC_LO = 6;
  localparam int CFG_DC_HI = 7;
  localparam int STAT_QUAD = 0;
  localparam int STAT_BUSY = 1;
  // Reset values
  localparam logic       SEG_RST  = 1'b0;
  localparam logic [7:0] CFG_RST  = 8'h00;
  // Dummy counts (per-command defaults for config field zero, then values for field 1 to 3), array mask, page size
  localparam logic [3:0] DUM_FAST = 4'h8;
  localparam logic [3:0] DUM_DIO  = 4'h4;
  localparam logic [3:0] DUM_QIO  = 4'h6;
  localparam logic [3:0] DUM_CF1  = 4'h6;
  localparam logic [3:0] DUM_CF2  = 4'h8;
  localparam logic [3:0] DUM_CF3  = 4'ha;
  localparam logic [31:0] ARR_MASK = 32'h01ff_ffff;
  localparam logic [8:0]  PAGE_MAX = 9'h100;
  // Opcodes, three/four byte address sets
  localparam logic [7:0] OP_RD    = 8'h03, OP_RD4    = 8'h13;
  localparam logic [7:0] OP_FRD   = 8'h0b, OP_FRD4   = 8'h0c;
  localparam logic [7:0] OP_DIO   = 8'hbb, OP_DIO4   = 8'hbc;
  localparam logic [7:0] OP_DOUT  = 8'h3b, OP_DOUT4  = 8'h3c;
  localparam logic [7:0] OP_QOUT  = 8'h6b, OP_QOUT4  = 8'h6c;
  localparam logic [7:0] OP_QIO_B = 8'heb, OP_QIO_T  = 8'hea;
  localparam logic [7:0] OP_QIO4  = 8'hec;
  localparam logic [7:0] OP_PG    = 8'h02, OP_PG4    = 8'h12;
  localparam logic [7:0] OP_QPG   = 8'h38, OP_QPG4   = 8'h3e;
  localparam logic [7:0] OP_SCT   = 8'h20, OP_SCT4   = 8'h21;
  localparam logic [7:0] OP_HB    = 8'h52, OP_HB4    = 8'h5c;
  localparam logic [7:0] OP_BLK   = 8'hd8, OP_BLK4   = 8'hdc;
  localparam logic [7:0] OP_CE_A  = 8'h60, OP_CE_B   = 8'hc7;
  localparam logic [7:0] OP_Q_ON  = 8'h35, OP_Q_OFF  = 8'hf5;
  // Wide-address entry/exit opcodes, arbitrary values
  localparam logic [7:0] OP_W_ON  = 8'ha7, OP_W_OFF  = 8'ha9;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_CMD = 9'h002, S_ADDR = 9'h004, S_DUMMY = 9'h008,
    S_RDATA = 9'h010, S_WDATA = 9'h020, S_DONE = 9'h040, S_REJ = 9'h080,
    S_COMMIT = 9'h100
  } fam_state_t;

  typedef enum logic [2:0] {
    C_RD, C_PG, C_ER, C_CE, C_W_ON, C_W_OFF, C_Q_ON, C_Q_OFF
  } fam_cls_t;

  typedef enum logic [2:0] {
    K_PROG, K_ER4K, K_ER32K, K_ER64K, K_CHIP
  } fam_kind_t;

  typedef struct packed {
    logic      ok;
    fam_cls_t  cls;
    fam_kind_t kind;
    logic      four;
    logic [2:0] al;
    logic [2:0] dl;
    logic [3:0] dum;
    logic      top;
    logic      bot;
  } fam_dec_t;

  typedef struct packed {
    logic       req;
    fam_kind_t  kind;
    logic [31:0] addr;
    logic [7:0] data;
  } fam_arr_cmd_t;
endpackage

// ===== hw/fam_core.sv
// Serial flash command interpreter with address modes and AHB-Lite registers
// How it works
// - Wide-address entry makes all addressed commands take 32-bit addresses until exit.
// - In wide-address mode the segment bit is ignored.
// - Dedicated four-byte opcodes always take a full 32-bit address.
// - Eight-bit volatile segment register supplies address bits 31..24 for 3-byte addresses.
// - Segment bits 7..1 read zero; bit 0 resets to 0, picks a half.
// - Three-byte reads (except EBh bottom / EAh top), programs, erases act in the selected half.
// - Continuous read rolls from end of a half into next, segment unchanged.
// - Random access start confined to the selected half.
// - Whole-array wipe 60h/C7h erases everything, ignoring the segment.
// - Opcode 35h enters four-line protocol, quad-pins flag untouched.
// - Opcode F5h returns to single-line command protocol.
// - 02h and 38h accept 1 to 256 bytes for the page.
// - 20h, 52h, D8h erase 4KB, 32KB, 64KB in either protocol.
// - Config bits 6 and 7 set the dummy count.
// - Write-type commands run only if deselect lands on a byte boundary.
// - Inputs sampled on rising clock edge, outputs shifted on falling edge.
// - Unknown command goes to standby, outputs off until next select.
//
// Chosen here: the AHB-Lite slave port and the address map.
module fam_core
  import fam_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire logic         cs_n,
  input  wire logic         sclk,
  input  wire logic [3:0]   io_in,
  output logic [3:0]        io_out,
  output logic [3:0]        io_oe,
  output logic [31:0]       arr_raddr,
  input  wire logic [7:0]   arr_rdata,
  output fam_arr_cmd_t      arr_cmd
);
  logic [2:0]   cs_s, sck_s;
  logic [3:0]   io_s1, io_s2;
  fam_state_t   st_q, st_d;
  fam_dec_t     dec_q, dec_d;
  fam_arr_cmd_t cmd_q, cmd_d;
  logic [5:0]   bc_q, bc_d, bn, alen;
  logic [31:0]  sh_q, sh_d, shn, ad_q, ad_d;
  logic [3:0]   dn_q, dn_d, dum, io_q, io_d, oe_q, oe_d;
  logic [7:0]   os_q, os_d, byt, ix_q, ix_d;
  logic [8:0]   cnt_q, cnt_d;
  logic [2:0]   ln;
  logic [1:0]   dcf_q, dcf_d;
  logic         seg_q, seg_d, wide_q, wide_d, qpe_q, qpe_d, quad_q, quad_d;
  logic         cs, cs_rise, cs_fall, sck_rise, sck_fall, fw, hi, we;
  logic         wr_q, wr_d;
  logic [7:0]   wa_q, wa_d;
  logic [31:0]  rd_q, rd_d;
  logic [7:0]   pbuf [256];

  // Two-flop synchronisers; edges taken from stages two and three
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_s  <= 3'h7;
      sck_s <= 3'h0;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end else begin
      cs_s  <= {cs_s[1:0], cs_n};
      sck_s <= {sck_s[1:0], sclk};
      io_s1 <= io_in;
      io_s2 <= io_s1;
    end
  end
  assign cs       = cs_s[1];
  assign cs_rise  = cs_s[1] & ~cs_s[2];
  assign cs_fall  = ~cs_s[1] & cs_s[2];
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];

  function automatic fam_dec_t dec(input logic [7:0] op, input logic q);
    fam_dec_t d;
    d      = '0;
    d.ok   = 1'b1;
    d.cls  = C_RD;
    d.kind = K_PROG;
    d.al   = 3'd1;
    d.dl   = 3'd1;
    d.four = op inside {OP_RD4, OP_FRD4, OP_DIO4, OP_DOUT4, OP_QOUT4, OP_QIO4,
                        OP_PG4, OP_QPG4, OP_SCT4, OP_HB4, OP_BLK4};
    case (op)
      OP_RD, OP_RD4: d.ok = ~q;
      OP_FRD, OP_FRD4: begin
        d.ok  = ~q;
        d.dum = DUM_FAST;
      end
      OP_DIO, OP_DIO4: begin
        d.ok  = ~q;
        d.al  = 3'd2;
        d.dl  = 3'd2;
        d.dum = DUM_DIO;
      end
      OP_DOUT, OP_DOUT4: begin
        d.ok  = ~q;
        d.dl  = 3'd2;
        d.dum = DUM_FAST;
      end
      OP_QOUT, OP_QOUT4: begin
        d.ok  = ~q;
        d.dl  = 3'd4;
        d.dum = DUM_FAST;
      end
      OP_QIO_B, OP_QIO_T, OP_QIO4: begin
        d.al  = 3'd4;
        d.dl  = 3'd4;
        d.dum = DUM_QIO;
        d.top = op == OP_QIO_T;
        d.bot = op == OP_QIO_B;
      end
      OP_PG, OP_PG4: d.cls = C_PG;
      OP_QPG, OP_QPG4: begin
        d.ok  = ~q;
        d.cls = C_PG;
        d.dl  = 3'd4;
      end
      OP_SCT, OP_SCT4: begin
        d.cls  = C_ER;
        d.kind = K_ER4K;
      end
      OP_HB, OP_HB4: begin
        d.cls  = C_ER;
        d.kind = K_ER32K;
      end
      OP_BLK, OP_BLK4: begin
        d.cls  = C_ER;
        d.kind = K_ER64K;
      end
      OP_CE_A, OP_CE_B: begin
        d.cls  = C_CE;
        d.kind = K_CHIP;
      end
      OP_W_ON:  d.cls = C_W_ON;
      OP_W_OFF: d.cls = C_W_OFF;
      OP_Q_ON: begin
        d.ok  = ~q;
        d.cls = C_Q_ON;
      end
      OP_Q_OFF: begin
        d.ok  = q;
        d.cls = C_Q_OFF;
      end
      default: d.ok = 1'b0;
    endcase
    if (q) begin
      d.al = 3'd4;
      d.dl = 3'd4;
    end
    return d;
  endfunction

  always_comb begin
    st_d   = st_q;
    dec_d  = dec_q;
    bc_d   = bc_q;
    sh_d   = sh_q;
    ad_d   = ad_q;
    dn_d   = dn_q;
    os_d   = os_q;
    io_d   = io_q;
    oe_d   = oe_q;
    cnt_d  = cnt_q;
    ix_d   = ix_q;
    cmd_d  = '0;
    seg_d  = seg_q;
    wide_d = wide_q;
    qpe_d  = qpe_q;
    dcf_d  = dcf_q;
    quad_d = quad_q;
    we     = 1'b0;
    byt    = os_q;
    ln     = (st_q == S_CMD) ? (quad_q ? 3'd4 : 3'd1) : (st_q == S_ADDR) ? dec_q.al : dec_q.dl;
    case (ln)
      3'd2:    shn = {sh_q[29:0], io_s2[1:0]};
      3'd4:    shn = {sh_q[27:0], io_s2};
      default: shn = {sh_q[30:0], io_s2[0]};
    endcase
    bn   = bc_q + {3'h0, ln};
    fw   = dec_q.four | wide_q;
    alen = fw ? 6'd32 : 6'd24;
    hi   = dec_q.top | (seg_q & ~dec_q.bot);
    unique case (dcf_q)
      2'd1:    dum = DUM_CF1;
      2'd2:    dum = DUM_CF2;
      2'd3:    dum = DUM_CF3;
      default: dum = dec_q.dum;
    endcase
    if (dec_q.dum == 4'h0) dum = 4'h0;
    if (wr_q && wa_q == REG_SEG) begin
      seg_d = hwdata[0];
    end
    if (wr_q && wa_q == REG_CFG) begin
      qpe_d  = hwdata[CFG_QPE];
      wide_d = hwdata[CFG_WIDE];
      dcf_d  = hwdata[CFG_DC_HI:CFG_DC_LO];
    end
    if (st_q == S_COMMIT) begin
      cmd_d.req  = 1'b1;
      cmd_d.kind = K_PROG;
      cmd_d.addr = {ad_q[31:8], ad_q[7:0] + ix_q};
      cmd_d.data = pbuf[ix_q];
      ix_d       = ix_q + 8'h1;
      if ({1'b0, ix_q} + 9'h1 == cnt_q) st_d = S_IDLE;
    end else if (cs_rise) begin
      oe_d = 4'h0;
      st_d = S_IDLE;
      // execute only when complete at a byte boundary
      if (st_q == S_DONE) begin
        unique case (dec_q.cls)
          C_ER, C_CE: begin
            cmd_d.req  = 1'b1;
            cmd_d.kind = dec_q.kind;
            cmd_d.addr = (dec_q.cls == C_CE) ? 32'h0 : ad_q;
          end
          C_W_ON:  wide_d = 1'b1;
          C_W_OFF: wide_d = 1'b0;
          C_Q_ON:  quad_d = 1'b1;
          C_Q_OFF: quad_d = 1'b0;
          default: ;
        endcase
      end else if (st_q == S_WDATA && bc_q == 6'h0 && cnt_q != 9'h0) begin
        st_d = S_COMMIT;
        ix_d = 8'h0;
      end
    end else if (cs_fall) begin
      st_d = S_CMD;
      bc_d = 6'h0;
      oe_d = 4'h0;
    end else if (sck_rise && !cs) begin
      unique case (st_q)
        S_CMD: begin
          sh_d = shn;
          bc_d = bn;
          if (bn == 6'd8) begin
            dec_d = dec(shn[7:0], quad_q);
            bc_d  = 6'h0;
            if (!dec_d.ok) st_d = S_REJ;
            else if (dec_d.cls inside {C_RD, C_PG, C_ER}) st_d = S_ADDR;
            else st_d = S_DONE;
          end
        end
        S_ADDR: begin
          sh_d = shn;
          bc_d = bn;
          if (bn == alen) begin
            bc_d = 6'h0;
            ad_d = fw ? shn : {7'h0, hi, shn[23:0]};
            if (dec_q.cls == C_ER) st_d = S_DONE;
            else if (dec_q.cls == C_PG) begin
              st_d  = S_WDATA;
              cnt_d = 9'h0;
            end else if (dum != 4'h0) begin
              st_d = S_DUMMY;
              dn_d = dum;
            end else st_d = S_RDATA;
          end
        end
        S_DUMMY: begin
          dn_d = dn_q - 4'h1;
          if (dn_q == 4'h1) st_d = S_RDATA;
        end
        S_WDATA: begin
          sh_d = shn;
          bc_d = bn;
          if (bn == 6'd8) begin
            bc_d = 6'h0;
            if (cnt_q != PAGE_MAX) begin
              we    = 1'b1;
              cnt_d = cnt_q + 9'h1;
            end
          end
        end
        // extra bits after a full command reject it
        S_DONE:  st_d = S_REJ;
        default: ;
      endcase
    end else if (sck_fall && !cs && st_q == S_RDATA) begin
      byt = (bc_q == 6'h0) ? arr_rdata : os_q;
      unique case (dec_q.dl)
        3'd2: begin
          io_d = {2'h0, byt[7:6]};
          oe_d = 4'h3;
          os_d = {byt[5:0], 2'h0};
        end
        3'd4: begin
          io_d = byt[7:4];
          oe_d = 4'hf;
          os_d = {byt[3:0], 4'h0};
        end
        default: begin
          io_d = {2'h0, byt[7], 1'b0};
          oe_d = 4'h2;
          os_d = {byt[6:0], 1'b0};
        end
      endcase
      bc_d = bc_q + {3'h0, dec_q.dl};
      if (bc_d == 6'd8) begin
        bc_d = 6'h0;
        ad_d = (ad_q + 32'h1) & ARR_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q   <= S_IDLE;
      dec_q  <= '0;
      bc_q   <= 6'h0;
      sh_q   <= 32'h0;
      ad_q   <= 32'h0;
      dn_q   <= 4'h0;
      os_q   <= 8'h0;
      io_q   <= 4'h0;
      oe_q   <= 4'h0;
      cnt_q  <= 9'h0;
      ix_q   <= 8'h0;
      cmd_q  <= '0;
      seg_q  <= SEG_RST;
      wide_q <= CFG_RST[CFG_WIDE];
      qpe_q  <= CFG_RST[CFG_QPE];
      dcf_q  <= CFG_RST[CFG_DC_HI:CFG_DC_LO];
      quad_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      dec_q  <= dec_d;
      bc_q   <= bc_d;
      sh_q   <= sh_d;
      ad_q   <= ad_d;
      dn_q   <= dn_d;
      os_q   <= os_d;
      io_q   <= io_d;
      oe_q   <= oe_d;
      cnt_q  <= cnt_d;
      ix_q   <= ix_d;
      cmd_q  <= cmd_d;
      seg_q  <= seg_d;
      wide_q <= wide_d;
      qpe_q  <= qpe_d;
      dcf_q  <= dcf_d;
      quad_q <= quad_d;
    end
  end

  // Page held until deselect so a ragged end can still be rejected
  always_ff @(posedge clk) begin
    if (we) pbuf[cnt_q[7:0]] <= shn[7:0];
  end

  // AHB-Lite slave, zero wait states; reads see same-cycle writes
  always_comb begin
    wr_d = hsel & hready & htrans[1] & hwrite;
    wa_d = haddr[7:0];
    rd_d = 32'h0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        REG_SEG:  rd_d = {31'h0, seg_d};
        REG_CFG:  rd_d = {24'h0, dcf_d, wide_d, 4'h0, qpe_d};
        REG_STAT: rd_d = {30'h0, st_q == S_COMMIT, quad_q};
        default:  rd_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      wa_q <= 8'h0;
      rd_q <= 32'h0;
    end else begin
      wr_q <= wr_d;
      wa_q <= wa_d;
      rd_q <= rd_d;
    end
  end

  assign hrdata    = rd_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign io_out    = io_q;
  assign io_oe     = oe_q;
  assign arr_raddr = ad_q;
  assign arr_cmd   = cmd_q;

  seg_rdzero_a: assert property (@(posedge clk) disable iff (!rst_n)
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == REG_SEG |=> hrdata[31:1] == 31'h0)
    else $error("segment upper bits not zero");
  wide_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == S_DONE && cs_rise && dec_q.cls == C_W_ON |=> wide_q ##1 wide_q)
    else $error("wide address flag not set");
  quad_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == S_DONE && cs_rise && dec_q.cls == C_Q_ON && !wr_q |=> quad_q && $stable(qpe_q))
    else $error("four-line entry wrong");
  quad_leave_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == S_DONE && cs_rise && dec_q.cls == C_Q_OFF |=> !quad_q)
    else $error("four-line exit failed");
  addr_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == S_ADDR && sck_rise && !cs && !cs_rise && dec_q.four && bn < 6'd32 |=> st_q == S_ADDR)
    else $error("four-byte address cut short");
  standby_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == S_REJ |-> io_oe == 4'h0)
    else $error("output driven in standby");
  chip_wipe_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == S_DONE && cs_rise && dec_q.cls == C_CE |=> arr_cmd.req && arr_cmd.kind == K_CHIP && arr_cmd.addr == 32'h0)
    else $error("whole-array wipe not issued");
  ragged_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_rise && st_q == S_WDATA && bc_q != 6'h0 |=> !arr_cmd.req && st_q == S_IDLE)
    else $error("ragged program executed");
  fall_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(io_out) && !$past(cs_rise) && !$past(cs_fall) |-> $past(sck_fall))
    else $error("output changed off falling edge");
endmodule

// ===== verif/fam_host.sv
// Serial host controller model: chip select, serial clock and data lanes
module fam_host (
  input  wire logic       clk,
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 24;
  parameter int DESEL_NS = 100;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_in = 4'h0;
  end
  task automatic tick;
    #HALF sclk = 1'b1;
    #HALF sclk = 1'b0;
  endtask
  // Offset keeps pin edges off the system clock edges
  task automatic start;
    @(negedge clk);
    #1.2 cs_n = 1'b0;
  endtask
  task automatic stop;
    #HALF cs_n = 1'b1;
    io_in = ~io_in;
    #DESEL_NS;
  endtask
  task automatic put(input logic [7:0] b, input int lanes, input int nbits);
    logic [7:0] s;
    s = b;
    for (int i = 0; i < nbits; i += lanes) begin
      io_in = lanes == 1 ? {~io_in[3:1], s[7]} : lanes == 2 ? {~io_in[3:2], s[7:6]} : s[7:4];
      s = s << lanes;
      tick;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      io_in = ~io_in;
      tick;
    end
  endtask
  task automatic get(output logic [7:0] b, output logic [3:0] oe, input int lanes);
    b = 8'h00;
    for (int i = 0; i < 8; i += lanes) begin
      #HALF;
      oe = io_oe;
      b = lanes == 1 ? {b[6:0], io_out[1]} : lanes == 2 ? {b[5:0], io_out[1:0]} : {b[3:0], io_out};
      sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
  endtask
endmodule

// ===== verif/fam_core_tb.sv
// Self-checking bench for the flash address-mode interpreter
module fam_core_tb import fam_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] EOP [3] = '{OP_SCT, OP_HB, OP_BLK};
  localparam fam_kind_t  EK [3]  = '{K_ER4K, K_ER32K, K_ER64K};
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         hsel = 1'b0;
  logic         hwrite = 1'b0;
  logic [1:0]   htrans = 2'b00;
  logic [31:0]  haddr = 32'h0;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata, arr_raddr, rdat_s;
  logic         hreadyout, hresp, cs_n, sclk, rdy_s;
  logic [3:0]   io_in, io_out, io_oe;
  logic [7:0]   arr_rdata;
  fam_arr_cmd_t arr_cmd;
  fam_arr_cmd_t cq[$];
  int           error_cnt = 0;
  int           samples_checked = 0;
  always #2.5 clk = ~clk;
  assign arr_rdata = arr_raddr[7:0] ^ arr_raddr[15:8] ^ {7'h0, arr_raddr[24]};
  fam_core fam_core_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .arr_raddr(arr_raddr),
    .arr_rdata(arr_rdata), .arr_cmd(arr_cmd));
  fam_host fam_host_inst (.clk(clk), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  // Settled copies taken mid-cycle, read after the next rising edge
  always @(negedge clk) begin
    rdy_s <= hreadyout;
    rdat_s <= hrdata;
  end
  always @(posedge clk) begin
    if (arr_cmd.req === 1'b1) cq.push_back(arr_cmd);
  end
  function automatic logic [7:0] exp_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ {7'h0, a[24]};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy_s !== 1'b1 && n < 50);
    if (rdy_s !== 1'b1) begin
      error_cnt++;
      test_done;
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    r = rdat_s;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic poll;
    logic [31:0] r;
    for (int n = 0; n < 100; n++) begin
      ahb(1'b0, REG_STAT, 32'h0, r);
      if (r[STAT_BUSY] === 1'b0) return;
    end
    error_cnt++;
    test_done;
  endtask
  task automatic cmd(input logic [7:0] op, input int ol, input int al, input int nab, input logic [31:0] a);
    fam_host_inst.start;
    fam_host_inst.put(op, ol, 8);
    for (int i = nab - 1; i >= 0; i--) fam_host_inst.put(a[8*i+:8], al, 8);
  endtask
  task automatic rdx(input logic [7:0] op, input int ol, input int al, input int dl, input int nab, input int dum,
                     input logic [31:0] a, input logic [31:0] ea);
    logic [7:0] b;
    logic [3:0] oe;
    cmd(op, ol, al, nab, a);
    fam_host_inst.idle(dum);
    for (int i = 0; i < 3; i++) begin
      fam_host_inst.get(b, oe, dl);
      chk({24'h0, b}, {24'h0, exp_byte((ea + i) & ARR_MASK)});
      chk({28'h0, oe}, dl == 1 ? 32'h2 : dl == 2 ? 32'h3 : 32'hf);
    end
    fam_host_inst.stop;
  endtask
  task automatic ecmd(input fam_kind_t k, input logic [31:0] a, input logic [7:0] d);
    fam_arr_cmd_t c;
    c = '0;
    if (cq.size() > 0) c = cq.pop_front();
    chk(c.addr, a);
    chk({20'h0, c.req, c.kind, k == K_PROG ? c.data : 8'h0}, {20'h0, 1'b1, k, k == K_PROG ? d : 8'h0});
  endtask
  task automatic dead(input logic [7:0] op, input int l);
    logic [7:0] b;
    logic [3:0] oe;
    fam_host_inst.start;
    fam_host_inst.put(op, l, 8);
    fam_host_inst.idle(8);
    fam_host_inst.get(b, oe, l);
    chk({28'h0, oe}, 32'h0);
    fam_host_inst.stop;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(REG_SEG, 32'h0);
    rchk(REG_CFG, {24'h0, CFG_RST});
    wreg(REG_SEG, 32'hff);
    rchk(REG_SEG, 32'h1);
    rchk(8'h40, 32'h0);
    rdx(OP_RD, 1, 1, 1, 3, 0, 32'hfffffe, 32'h1fffffe);
    rchk(REG_SEG, 32'h1);
    rdx(OP_RD, 1, 1, 1, 3, 0, 32'h00abcd, 32'h100abcd);
    rdx(OP_QIO_B, 1, 4, 4, 3, 6, 32'h123456, 32'h123456);
    rdx(OP_QIO_T, 1, 4, 4, 3, 6, 32'h123456, 32'h1123456);
    wreg(REG_SEG, 32'h0);
    rdx(OP_FRD, 1, 1, 1, 3, 8, 32'h1fffff, 32'h1fffff);
    rdx(OP_DOUT, 1, 1, 2, 3, 8, 32'h00a5c3, 32'h00a5c3);
    rdx(OP_DIO, 1, 2, 2, 3, 4, 32'h3c5a00, 32'h3c5a00);
    rdx(OP_QOUT, 1, 1, 4, 3, 8, 32'h7e8100, 32'h7e8100);
    rdx(OP_RD4, 1, 1, 1, 4, 0, 32'h01234567, 32'h01234567);
    wreg(REG_CFG, 32'h40);
    rdx(OP_FRD, 1, 1, 1, 3, DUM_CF1, 32'h000100, 32'h000100);
    wreg(REG_CFG, 32'hc0);
    rdx(OP_FRD, 1, 1, 1, 3, DUM_CF3, 32'h000200, 32'h000200);
    wreg(REG_CFG, 32'h0);
    wreg(REG_SEG, 32'h1);
    foreach (EOP[i]) begin
      cmd(EOP[i], 1, 1, 3, 32'h345678);
      fam_host_inst.stop;
      ecmd(EK[i], 32'h1345678, 8'h0);
    end
    cmd(OP_CE_A, 1, 1, 0, 32'h0);
    fam_host_inst.stop;
    ecmd(K_CHIP, 32'h0, 8'h0);
    cmd(OP_CE_B, 1, 1, 0, 32'h0);
    fam_host_inst.stop;
    ecmd(K_CHIP, 32'h0, 8'h0);
    cmd(OP_SCT, 1, 1, 2, 32'h1234);
    fam_host_inst.put(8'h56, 1, 7);
    fam_host_inst.stop;
    chk(32'(cq.size()), 32'h0);
    cmd(OP_W_ON, 1, 1, 0, 32'h0);
    fam_host_inst.stop;
    rchk(REG_CFG, 32'h20);
    cmd(OP_SCT, 1, 1, 4, 32'h00aaaaaa);
    fam_host_inst.stop;
    ecmd(K_ER4K, 32'h00aaaaaa, 8'h0);
    cmd(OP_W_OFF, 1, 1, 0, 32'h0);
    fam_host_inst.stop;
    rchk(REG_CFG, 32'h0);
    cmd(OP_PG, 1, 1, 3, 32'h000010);
    fam_host_inst.put(8'ha5, 1, 8);
    fam_host_inst.put(8'h5a, 1, 8);
    fam_host_inst.stop;
    poll;
    ecmd(K_PROG, 32'h1000010, 8'ha5);
    ecmd(K_PROG, 32'h1000011, 8'h5a);
    cmd(OP_QPG, 1, 1, 3, 32'h000020);
    fam_host_inst.put(8'h3c, 4, 8);
    fam_host_inst.stop;
    poll;
    ecmd(K_PROG, 32'h1000020, 8'h3c);
    // Page write cut three bits into its second byte
    cmd(OP_PG, 1, 1, 3, 32'h000030);
    fam_host_inst.put(8'h11, 1, 8);
    fam_host_inst.put(8'h22, 1, 3);
    fam_host_inst.stop;
    chk(32'(cq.size()), 32'h0);
    wreg(REG_CFG, 32'h1);
    cmd(OP_Q_ON, 1, 1, 0, 32'h0);
    fam_host_inst.stop;
    rchk(REG_STAT, 32'h1);
    rchk(REG_CFG, 32'h1);
    rdx(OP_QIO_B, 4, 4, 4, 3, 6, 32'h654321, 32'h654321);
    dead(OP_QOUT, 4);
    cmd(OP_BLK, 4, 4, 3, 32'h010000);
    fam_host_inst.stop;
    ecmd(K_ER64K, 32'h1010000, 8'h0);
    cmd(OP_Q_OFF, 4, 4, 0, 32'h0);
    fam_host_inst.stop;
    rchk(REG_STAT, 32'h0);
    dead(8'hff, 1);
    test_done;
  end
endmodule
